// *** hw/pmic_map.vh ***
// Register offsets, field positions, vectors and timing counts of the power monitor interrupt controller.
//
// Behaviour
// - Count 65536 clocks after supply recovers, start 0000h
// - Reset held while supply below threshold
// - Power-on flag in control bit 6
// - Drive reset pin high during supply reset
// - Enabled supply warning vectors to 0033h
// - Warning enable is control bit 5
// - Warning flag bit 4, set always, software clears
// - Warning ignores global enable; others need both
// - Global enable is enable register bit 7
// - Three levels; warning highest; priority bit selects
// - Equal level: lowest natural number wins
// - Sixteen sources with flag, enable, vector
// - Port B source: vector 0Bh, natural 2
// - Port A source: vector 6Bh, natural 13
// - Ext2 or capture0: vector 23h, natural 5
`ifndef PMIC_MAP_VH
`define PMIC_MAP_VH
`define PMIC_ADDR_WATCHDOG_CONTROL_REG   12'h000
`define PMIC_ADDR_IE      12'h004
`define PMIC_ADDR_IP      12'h008
`define PMIC_ADDR_EIE     12'h00C
`define PMIC_ADDR_EIP     12'h010
`define PMIC_ADDR_CAPTURE_TRIGGER_CTRL_REG   12'h014
`define PMIC_ADDR_STATUS  12'h018
`define PMIC_BIT_POR      6
`define PMIC_BIT_WEN      5
`define PMIC_BIT_WFLG     4
`define PMIC_BIT_GEN      7
`define PMIC_STARTUP_CYC  17'h1_0000
`define PMIC_RESET_PC     16'h0000
`define PMIC_WARN_VEC     16'h0033
`define PMIC_LVL_NONE     2'h0
`define PMIC_LVL_LOW      2'h1
`define PMIC_LVL_HIGH     2'h2
`define PMIC_LVL_TOP      2'h3
`define PMIC_VEC_SRC1     16'h0003
`define PMIC_VEC_SRC2     16'h000B
`define PMIC_VEC_SRC3     16'h0013
`define PMIC_VEC_SRC4     16'h001B
`define PMIC_VEC_SRC5     16'h0023
`define PMIC_VEC_SRC6     16'h002B
`define PMIC_VEC_SRC7     16'h003B
`define PMIC_VEC_SRC8     16'h0043
`define PMIC_VEC_SRC9     16'h004B
`define PMIC_VEC_SRC10    16'h0053
`define PMIC_VEC_SRC11    16'h005B
`define PMIC_VEC_SRC12    16'h0063
`define PMIC_VEC_SRC13    16'h006B
`define PMIC_VEC_SRC14    16'h0073
`define PMIC_VEC_SRC15    16'h007B
`endif

// *** hw/pmic_top.v ***
// Supply monitor, reset sequencer and sixteen source interrupt controller with APB registers.
`include "pmic_map.vh"
module pmic_top (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        supply_ok,
    input  wire        supply_warn,
    input  wire [15:0] irq_src,
    input  wire        irq_ack,
    input  wire        irq_ret,
    output reg         core_rst,
    output reg         rst_pin_o,
    output reg         rst_pin_oe,
    output reg         irq_req,
    output reg  [15:0] irq_vector,
    output reg  [15:0] fetch_addr
);
    ////////////////////////////////////////////////////////////////////////////////
    reg  [2:0]  ok_s_q;
    reg  [2:0]  warn_s_q;
    reg         ok_q;
    reg         warn_q;
    reg         warn_prev_q;
    reg  [16:0] start_cnt_q;
    reg         por_q;
    reg         wen_q;
    reg         wflg_q;
    reg  [7:0]  ie_q;
    reg  [7:0]  ip_q;
    reg  [7:0]  eie_q;
    reg  [7:0]  eip_q;
    reg  [7:0]  capture_trigger_ctrl_reg_q;
    reg  [3:0]  act_q;
    reg  [3:0]  act_src_q [0:3];
    wire [15:0] en_map;
    wire [15:0] pr_map;
    wire        acc;
    // Per-source enable and priority bits taken from the four control registers.
    assign en_map = {eie_q[7], eie_q[3], ie_q[4], eie_q[6], eie_q[2], ie_q[3], eie_q[5], eie_q[1],
                     ie_q[2], eie_q[4], eie_q[0], ie_q[1], ie_q[6], ie_q[5], ie_q[0], 1'b0};
    assign pr_map = {eip_q[7], eip_q[3], ip_q[4], eip_q[6], eip_q[2], ip_q[3], eip_q[5], eip_q[1],
                     ip_q[2], eip_q[4], eip_q[0], ip_q[1], ip_q[6], ip_q[5], ip_q[0], 1'b0};
    assign acc = psel & penable & pready;
    ////////////////////////////////////////////////////////////////////////////////
    // Supply comparators arrive asynchronously; a change counts once stages two and three agree.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ok_s_q      <= 3'h0;
            warn_s_q    <= 3'h0;
            ok_q        <= 1'b0;
            warn_q      <= 1'b0;
            warn_prev_q <= 1'b0;
        end else begin
            ok_s_q   <= {ok_s_q[1:0], supply_ok};
            warn_s_q <= {warn_s_q[1:0], supply_warn};
            if (ok_s_q[2] == ok_s_q[1])
                ok_q <= ok_s_q[2];
            if (warn_s_q[2] == warn_s_q[1])
                warn_q <= warn_s_q[2];
            warn_prev_q <= warn_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Reset sequencer: any supply dip that ok_q sees, after filtering, restarts the whole power-on count.
    localparam [1:0] SEQ_HOLD  = 2'h0;
    localparam [1:0] SEQ_COUNT = 2'h1;
    localparam [1:0] SEQ_RUN   = 2'h2;
    reg  [1:0]  seq_q;
    reg  [1:0]  seq_d;
    reg  [16:0] start_cnt_d;
    always @* begin
        seq_d       = seq_q;
        start_cnt_d = start_cnt_q;
        case (seq_q)
            SEQ_HOLD: begin
                start_cnt_d = 17'h0_0000;
                if (ok_q)
                    seq_d = SEQ_COUNT;
            end
            SEQ_COUNT: begin
                if (!ok_q) begin
                    seq_d       = SEQ_HOLD;
                    start_cnt_d = 17'h0_0000;
                end else if (start_cnt_q == `PMIC_STARTUP_CYC) begin
                    seq_d       = SEQ_RUN;
                end else begin
                    start_cnt_d = start_cnt_q + 17'h0_0001;
                end
            end
            SEQ_RUN: begin
                if (!ok_q) begin
                    seq_d       = SEQ_HOLD;
                    start_cnt_d = 17'h0_0000;
                end
            end
            default: begin
                seq_d       = SEQ_HOLD;
                start_cnt_d = 17'h0_0000;
            end
        endcase
    end
    // Outputs follow the next state so the pin and core react in the same cycle.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            seq_q       <= SEQ_HOLD;
            start_cnt_q <= 17'h0_0000;
            core_rst    <= 1'b1;
            rst_pin_o   <= 1'b1;
            rst_pin_oe  <= 1'b1;
            fetch_addr  <= `PMIC_RESET_PC;
        end else begin
            seq_q       <= seq_d;
            start_cnt_q <= start_cnt_d;
            core_rst    <= (seq_d != SEQ_RUN);
            rst_pin_o   <= (seq_d == SEQ_HOLD);
            rst_pin_oe  <= (seq_d == SEQ_HOLD);
            fetch_addr  <= `PMIC_RESET_PC;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Registers; hardware sets of the two flags win over a software clear in the same cycle.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            por_q   <= 1'b1;
            wen_q   <= 1'b0;
            wflg_q  <= 1'b0;
            ie_q    <= 8'h00;
            ip_q    <= 8'h00;
            eie_q   <= 8'h00;
            eip_q   <= 8'h00;
            capture_trigger_ctrl_reg_q <= 8'h00;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~pready;
            pslverr <= 1'b0;
            if (psel & ~pready & ~pwrite) begin
                case (paddr)
                    `PMIC_ADDR_WATCHDOG_CONTROL_REG:  prdata <= {25'h000_0000, por_q, wen_q, wflg_q, 4'h0};
                    `PMIC_ADDR_IE:     prdata <= {24'h00_0000, ie_q};
                    `PMIC_ADDR_IP:     prdata <= {24'h00_0000, ip_q};
                    `PMIC_ADDR_EIE:    prdata <= {24'h00_0000, eie_q};
                    `PMIC_ADDR_EIP:    prdata <= {24'h00_0000, eip_q};
                    `PMIC_ADDR_CAPTURE_TRIGGER_CTRL_REG:  prdata <= {24'h00_0000, capture_trigger_ctrl_reg_q};
                    `PMIC_ADDR_STATUS: prdata <= {12'h000, act_q, irq_src};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
            if (psel & ~pready) begin
                case (paddr)
                    `PMIC_ADDR_WATCHDOG_CONTROL_REG, `PMIC_ADDR_IE, `PMIC_ADDR_IP, `PMIC_ADDR_EIE,
                    `PMIC_ADDR_EIP, `PMIC_ADDR_CAPTURE_TRIGGER_CTRL_REG, `PMIC_ADDR_STATUS: pslverr <= 1'b0;
                    default: pslverr <= 1'b1;
                endcase
            end
            if (acc & pwrite) begin
                case (paddr)
                    `PMIC_ADDR_WATCHDOG_CONTROL_REG: begin
                        por_q  <= pwdata[`PMIC_BIT_POR];
                        wen_q  <= pwdata[`PMIC_BIT_WEN];
                        wflg_q <= pwdata[`PMIC_BIT_WFLG];
                    end
                    `PMIC_ADDR_IE:    ie_q    <= pwdata[7:0];
                    `PMIC_ADDR_IP:    ip_q    <= pwdata[7:0];
                    `PMIC_ADDR_EIE:   eie_q   <= pwdata[7:0];
                    `PMIC_ADDR_EIP:   eip_q   <= pwdata[7:0];
                    `PMIC_ADDR_CAPTURE_TRIGGER_CTRL_REG: capture_trigger_ctrl_reg_q <= pwdata[7:0];
                    default: ;
                endcase
            end
            if (!ok_q)
                por_q <= 1'b1;
            if (warn_q & ~warn_prev_q)
                wflg_q <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Per-source pending bit and level; source 0 is the supply warning on the reserved top level.
    wire [15:0] pend;
    wire [31:0] src_lvl;
    assign pend[0]      = wflg_q & wen_q;
    assign src_lvl[1:0] = `PMIC_LVL_TOP;
    genvar g;
    generate
        for (g = 1; g < 16; g = g + 1) begin : g_src
            assign pend[g]             = irq_src[g] & en_map[g] & ie_q[`PMIC_BIT_GEN];
            assign src_lvl[2*g+1:2*g]  = pr_map[g] ? `PMIC_LVL_HIGH : `PMIC_LVL_LOW;
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////////////
    // Arbiter: highest level first, lowest natural number within a level.
    reg  [1:0]  best_lvl;
    reg  [3:0]  best_src;
    reg  [1:0]  cand_lvl;
    integer     i;
    always @* begin
        best_lvl = `PMIC_LVL_NONE;
        best_src = 4'h0;
        cand_lvl = `PMIC_LVL_NONE;
        // Scanning downwards lets a lower natural number take over an equal level.
        for (i = 15; i >= 0; i = i - 1) begin
            cand_lvl = src_lvl[2*i +: 2];
            if (pend[i] && (cand_lvl >= best_lvl)) begin
                best_lvl = cand_lvl;
                best_src = i[3:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Fixed vector table; the slot at 0033h belongs to the supply warning, so the table skips it.
    reg  [15:0] vec_d;
    always @* begin
        case (best_src)
            4'h0:    vec_d = `PMIC_WARN_VEC;
            4'h1:    vec_d = `PMIC_VEC_SRC1;
            4'h2:    vec_d = `PMIC_VEC_SRC2;
            4'h3:    vec_d = `PMIC_VEC_SRC3;
            4'h4:    vec_d = `PMIC_VEC_SRC4;
            4'h5:    vec_d = `PMIC_VEC_SRC5;
            4'h6:    vec_d = `PMIC_VEC_SRC6;
            4'h7:    vec_d = `PMIC_VEC_SRC7;
            4'h8:    vec_d = `PMIC_VEC_SRC8;
            4'h9:    vec_d = `PMIC_VEC_SRC9;
            4'hA:    vec_d = `PMIC_VEC_SRC10;
            4'hB:    vec_d = `PMIC_VEC_SRC11;
            4'hC:    vec_d = `PMIC_VEC_SRC12;
            4'hD:    vec_d = `PMIC_VEC_SRC13;
            4'hE:    vec_d = `PMIC_VEC_SRC14;
            4'hF:    vec_d = `PMIC_VEC_SRC15;
            default: vec_d = `PMIC_WARN_VEC;
        endcase
    end
    // Request is raised only when the winner outranks the running routine.
    always @(posedge sys_clk) begin
        if (sys_rst | core_rst) begin
            act_q      <= 4'h0;
            irq_req    <= 1'b0;
            irq_vector <= `PMIC_WARN_VEC;
        end else begin
            irq_req <= (best_lvl > act_q[3:2]) & ~irq_ack;
            irq_vector <= vec_d;
            if (irq_ack & irq_req)
                act_q <= {best_lvl, act_q[3:2]};
            else if (irq_ret)
                act_q <= {act_q[1:0], `PMIC_LVL_NONE};
        end
    end
endmodule

// *** test/pmic_monitor.sv ***
// Port checker of the power monitor interrupt controller, bound to its top module.
module pmic_monitor (
    input wire        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr,
    input wire        supply_ok, irq_req, core_rst, rst_pin_o, rst_pin_oe,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire [15:0] irq_vector, fetch_addr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [19:0] cnt_q;
    // Counts the clocks the core is held while the supply is good.
    always @(posedge sys_clk) begin
        if (sys_rst || !supply_ok || !core_rst) cnt_q <= 20'h0_0000;
        else cnt_q <= cnt_q + 20'h0_0001;
    end
    sequence s_low; !supply_ok [*6]; endsequence
    sequence s_setup; psel && !penable; endsequence
    AST_FETCH_ZERO: assert property (fetch_addr == 16'h0000) else $error("start address not zero");
    AST_START_COUNT: assert property ($fell(core_rst) |-> cnt_q >= 20'h1_0000 && cnt_q <= 20'h1_0008)
        else $error("core released after wrong count");
    AST_HOLD_LOW: assert property (s_low |-> core_rst) else $error("core not held on low supply");
    AST_PIN_DRIVE: assert property (s_low |-> rst_pin_oe && rst_pin_o) else $error("reset pin not driven");
    AST_QUIET: assert property (core_rst && $past(core_rst) |-> !irq_req) else $error("request during reset");
    AST_VEC_MAP: assert property (irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h007B)
        else $error("vector outside table");
    AST_ONE_WAIT: assert property (s_setup |=> pready ##1 !pready) else $error("ready timing wrong");
    AST_BAD_ADDR: assert property (psel && penable && pready && paddr > 12'h018 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
endmodule
bind pmic_top pmic_monitor u_pmic_monitor (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .pready, .pslverr, .supply_ok,
    .irq_req, .core_rst, .rst_pin_o, .rst_pin_oe, .paddr, .prdata, .irq_vector, .fetch_addr);

// *** test/pmic_core_model.sv ***
// Behavioural processor core that takes and returns interrupts.
module pmic_core_model (
    input  wire logic sys_clk, sys_rst, irq_req, slow,
    output logic      irq_ack, irq_ret
);
    timeunit 1ns;
    timeprecision 1ps;
    int w, h;
    always @(posedge sys_clk) begin
        irq_ack <= 1'h0;
        irq_ret <= 1'h0;
        if (sys_rst) begin
            w <= 0;
            h <= 0;
        end else begin
            if (h > 0) h <= h - 1;
            if (h == 1) irq_ret <= 1'h1;
            if (irq_req && !(h > 26)) begin
                w <= w + 1;
                if (w >= (slow ? 4 : 0)) begin
                    irq_ack <= 1'h1;
                    w <= 0;
                    h <= 30;
                end
            end
        end
    end
endmodule

// *** test/pmic_top_tb_top.sv ***
// Self-checking bench of the power monitor interrupt controller.
module pmic_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0, sys_rst, psel, penable, pwrite, pready, pslverr, supply_ok, supply_warn, slow, perr;
    logic irq_ack, irq_ret, core_rst, rst_pin_o, rst_pin_oe, irq_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] irq_src, irq_vector, fetch_addr;
    logic [3:0]  ecode [15] = '{4'h0, 4'h5, 4'h6, 4'h1, 4'h8, 4'hC, 4'h2, 4'h9, 4'hD, 4'h3, 4'hA, 4'hE, 4'h4, 4'hB, 4'hF};
    logic [7:0]  vec [15] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63,
                             8'h6B, 8'h73, 8'h7B};
    int n_errors = 0, num_checks = 0, i;
    pmic_top u_pmic_top (.*);
    pmic_core_model u_pmic_core_model (.sys_clk, .sys_rst, .irq_req, .slow, .irq_ack, .irq_ret);
    always #20 sys_clk = ~sys_clk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task wreq();
        for (int k = 0; k < 200; k++) begin
            @(negedge sys_clk);
            if (irq_req === 1'b1) break;
        end
        chk(irq_req, 1'h1);
    endtask
    task finish_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #3600000;
        n_errors++;
        finish_test();
    end
    initial begin
        {sys_rst, supply_ok, psel, penable, pwrite, supply_warn, slow, paddr, pwdata, irq_src} = {2'h3, 65'h0};
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'h0;
        for (i = 0; i < 70000 && core_rst !== 1'b0; i++) @(negedge sys_clk);
        chk(i >= 65536 && i <= 65545, 1'h1);
        chk(fetch_addr, 16'h0000);
        apb(1'h0, 12'h000, 32'h0);
        chk(q[6], 1'h1);
        apb(1'h1, 12'h000, 32'h0);
        apb(1'h0, 12'h000, 32'h0);
        chk(q[6], 1'h0);
        apb(1'h1, 12'h014, 32'h0000_00FF);
        for (int n = 1; n < 16; n++) begin
            apb(1'h1, 12'h004, ecode[n-1][3] ? 32'h80 : 32'h80 | 32'h1 << ecode[n-1][2:0]);
            apb(1'h1, 12'h00C, ecode[n-1][3] ? 32'h1 << ecode[n-1][2:0] : 32'h0);
            irq_src <= 16'h1 << n;
            wreq();
            chk(irq_vector, vec[n-1]);
            @(posedge sys_clk) irq_src <= 16'h0;
            repeat (40) @(posedge sys_clk);
        end
        apb(1'h1, 12'h004, 32'h1);
        irq_src <= 16'h0002;
        repeat (20) @(negedge sys_clk);
        chk(irq_req, 1'h0);
        apb(1'h1, 12'h000, 32'h20);
        supply_warn <= 1'h1;
        wreq();
        chk(irq_vector, 16'h0033);
        apb(1'h0, 12'h000, 32'h0);
        chk(q[4], 1'h1);
        {supply_warn, irq_src} <= 17'h0;
        repeat (40) @(posedge sys_clk);
        apb(1'h1, 12'h000, 32'h0);
        apb(1'h0, 12'h000, 32'h0);
        chk(q[4], 1'h0);
        supply_warn <= 1'h1;
        repeat (20) @(negedge sys_clk);
        chk(irq_req, 1'h0);
        apb(1'h0, 12'h000, 32'h0);
        chk(q[4], 1'h1);
        supply_warn <= 1'h0;
        apb(1'h1, 12'h004, 32'hB0);
        irq_src <= 16'h2004;
        wreq();
        chk(irq_vector, 16'h000B);
        @(posedge sys_clk) irq_src <= 16'h0;
        repeat (40) @(posedge sys_clk);
        slow <= 1'h1;
        apb(1'h1, 12'h008, 32'h10);
        irq_src <= 16'h0004;
        wreq();
        repeat (8) @(posedge sys_clk);
        irq_src <= 16'h2004;
        wreq();
        chk(irq_vector, 16'h006B);
        apb(1'h0, 12'h01C, 32'h0);
        chk(perr, 1'h1);
        chk(q, 32'h0);
        supply_ok <= 1'h0;
        repeat (6) @(negedge sys_clk);
        chk({core_rst, rst_pin_oe, rst_pin_o}, 3'h7);
        finish_test();
    end
endmodule
